/* smc_core.sv */
// Purpose: Serial instruction decoder and memory access sequencer
// Assumes: Link signals oversampled by CLK, modes (0,0) and (1,1)
// Notes:   Memory contents start undefined until written
`timescale 1ns/10ps
//Function
//- Latch set only by set; cleared otherwise
//- Status write needs latch and pin permission
//- Last status byte of frame is used
//- Permitted status write programs, then clears latch
//- Refused status write keeps latch, no cycle
//- First read after status write reads upper
//- Only status read runs while busy
//- Status byte refreshed and repeated each byte
//- Restore reloads PIO registers from defaults
//- Start address selects write handling
//- User write buffer offset wraps in segment
//- User program needs unprotected, latch, full bytes
//- Rejected user write keeps latch
//- Register segment skips first ten bytes
//- Volatile bytes write directly when allowed
//- Volatile pointer wraps 135h to 120h
//- Latch cleared only if volatile byte written
//- PIO output pointer alternates in low current
//- Read-only and missing ranges discard writes
//- Volatile commit on LSB fall or frame end
//- Read from 135h or below sends status byte before data
//- Read zeros reserved, wraps 135h to 000h
//- Latch and status-write opcode values
//- Remaining opcode values, X is A8
//- Status byte field layout
module smc_core
  import smc_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYC,
  parameter int PIO_CYCLES  = PIO_CYC
)(
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // Serial link
  input  wire logic       SCK,
  input  wire logic       CS_N,
  input  wire logic       MOSI,
  output logic            MISO,
  output logic            MISO_OE,
  // Protection pin and PIO mode
  input  wire logic       PROTECT_PIN_N,
  input  wire logic       HIGH_CURRENT_MODE,
  // Status byte
  output logic [7:0]      STATUS
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic smc_region_type region_of(input logic [8:0] a);
    if (a < A_REG_LO)      region_of = RG_USR;
    else if (a < A_RO_LO)  region_of = RG_REG;
    else if (a < A_VOL_LO) region_of = RG_RO;
    else if (a <= A_VOL_HI) region_of = RG_VOL;
    else                   region_of = RG_NONE;
  endfunction

  function automatic logic blk_prot(input logic [1:0] bp,
                                    input logic [4:0] seg);
    case (bp)
      2'h1:    blk_prot = (seg[3:2] == 2'h3);
      2'h2:    blk_prot = seg[3];
      2'h3:    blk_prot = 1'b1;
      default: blk_prot = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // Link synchronisers
  // ****************************************************************
  logic sck_s1, sck_s2, sck_s3, cs_s1, cs_s2, cs_s3;
  logic mosi_s1, mosi_s2, pin_s1, pin_s2;

  // Two flops per pin, third flop for edges
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      {sck_s1, sck_s2, sck_s3} <= 3'h0;
      {cs_s1, cs_s2, cs_s3}    <= 3'h7;
      {mosi_s1, mosi_s2}       <= 2'h0;
      {pin_s1, pin_s2}         <= 2'h0;
    end
    else
    begin
      {sck_s1, sck_s2, sck_s3} <= {SCK, sck_s1, sck_s2};
      {cs_s1, cs_s2, cs_s3}    <= {CS_N, cs_s1, cs_s2};
      {mosi_s1, mosi_s2}       <= {MOSI, mosi_s1};
      {pin_s1, pin_s2}         <= {PROTECT_PIN_N, pin_s1};
    end
  end

  // ****************************************************************
  // Core state
  // ****************************************************************
  smc_state_type  st_r, st_nxt;
  smc_region_type rg_r, rg_nxt;
  smc_kind_type   kind_r, kind_nxt;
  logic [2:0]  bcnt_r, bcnt_nxt;
  logic [6:0]  sh_r, sh_nxt;
  logic [8:0]  ptr_r, ptr_nxt, padr_r, padr_nxt;
  logic [7:0]  pdat_r, pdat_nxt, swr_r, swr_nxt, osr_r, osr_nxt;
  logic [5:0]  nv_r, nv_nxt;
  logic [4:0]  seg_r, seg_nxt, step_r, step_nxt;
  logic [15:0] mask_r, mask_nxt;
  logic [31:0] bsy_r, bsy_nxt;
  logic ophi_r, ophi_nxt, tog_r, tog_nxt, first_r, first_nxt;
  logic wrany_r, wrany_nxt, pend_r, pend_nxt, swok_r, swok_nxt;
  logic aswr_r, aswr_nxt, wel_r, wel_nxt, wip_r, wip_nxt;
  logic ld_r, ld_nxt, srcst_r, srcst_nxt, oe_r, oe_nxt;
  logic act, rise, fall, csr, byte_done, busy, commit_ok;
  logic [7:0]  rx, mrd, brd, mw_data;
  logic [8:0]  mr_addr, mw_addr, a9;
  logic [4:0]  sm1;
  logic mw_en, bw_en;

  assign act       = ~cs_s2;
  assign rise      = act & sck_s2 & ~sck_s3;
  assign fall      = act & ~sck_s2 & sck_s3;
  assign csr       = cs_s2 & ~cs_s3;
  assign byte_done = rise & (bcnt_r == 3'h7);
  assign rx        = {sh_r, mosi_s2};
  assign busy      = (bsy_r != 32'h0);
  assign sm1       = step_r - 5'h01;
  assign commit_ok = pend_r & (fall | csr) & wel_r
                   & ~nv_r[NV_LOCK]
                   & (padr_r != A_PIN_A) & (padr_r != A_PIN_B);

  // Next-state decode of the frame, pointer and busy engine
  always_comb
  begin
    st_nxt = st_r;  rg_nxt = rg_r;  kind_nxt = kind_r;
    bcnt_nxt = bcnt_r;  sh_nxt = sh_r;  ptr_nxt = ptr_r;
    padr_nxt = padr_r;  pdat_nxt = pdat_r;  swr_nxt = swr_r;
    osr_nxt = osr_r;  nv_nxt = nv_r;  seg_nxt = seg_r;
    step_nxt = step_r;  mask_nxt = mask_r;  bsy_nxt = bsy_r;
    ophi_nxt = ophi_r;  tog_nxt = tog_r;  first_nxt = first_r;
    wrany_nxt = wrany_r | commit_ok;
    pend_nxt = pend_r & ~(fall | csr);
    swok_nxt = swok_r;  aswr_nxt = aswr_r;  wel_nxt = wel_r;
    wip_nxt = wip_r;  ld_nxt = ld_r;  srcst_nxt = srcst_r;
    a9 = {ophi_r, rx};
    oe_nxt = act & ((st_r == S_RD) | (st_r == S_SR));
    if (rise)
    begin
      sh_nxt = rx[6:0];
      bcnt_nxt = bcnt_r + 3'h1;
    end
    if (byte_done)
      case (st_r)
        S_OP:
        begin
          st_nxt = S_IGN;
          if (rx == OP_ST_RD)
          begin
            st_nxt = S_SR;
            ld_nxt = 1'b1;
            srcst_nxt = 1'b1;
          end
          else if (!busy)
          begin
            if (rx == OP_SET_WEL) wel_nxt = 1'b1;
            else if (rx == OP_CLR_WEL) wel_nxt = 1'b0;
            else if (rx == OP_ST_WR) st_nxt = S_SW;
            else if (rx == OP_RESTORE)
            begin
              bsy_nxt = 32'(PIO_CYCLES);
              kind_nxt = K_RST;
              step_nxt = 5'h00;
            end
            else if (rx[7:4] == 4'h0 && (rx[2:0] == OP_MEM_WR ||
                     rx[2:0] == OP_MEM_RD))
            begin
              st_nxt = S_ADR;
              ophi_nxt = rx[3];
              first_nxt = rx[0];
            end
          end
        end
        S_ADR:
          if (first_r)
          begin
            if (aswr_r) a9[8] = 1'b1;
            aswr_nxt = 1'b0;
            ptr_nxt = a9;
            st_nxt = S_RD;
            ld_nxt = 1'b1;
            srcst_nxt = (a9 <= A_VOL_HI);
            first_nxt = (a9 <= A_VOL_HI);
          end
          else
          begin
            ptr_nxt = a9;
            rg_nxt = region_of(a9);
            seg_nxt = a9[8:4];
            tog_nxt = (a9 == A_VOL_LO || a9 == A_PIO_B)
                    & ~HIGH_CURRENT_MODE;
            st_nxt = S_WR;
          end
        S_WR:
          case (rg_r)
            RG_USR, RG_REG:
            begin
              if (rg_r == RG_USR || ptr_r[3:0] >= REG_SKIP)
                mask_nxt[ptr_r[3:0]] = 1'b1;
              ptr_nxt[3:0] = ptr_r[3:0] + 4'h1;
            end
            RG_VOL:
            begin
              pend_nxt = 1'b1;
              padr_nxt = ptr_r;
              pdat_nxt = rx;
              if (tog_r)
                ptr_nxt = (ptr_r == A_VOL_LO) ? A_PIO_B
                                              : A_VOL_LO;
              else if (ptr_r == A_VOL_HI)
                ptr_nxt = A_VOL_LO;
              else
                ptr_nxt = ptr_r + 9'h001;
            end
            default: ;
          endcase
        S_RD:
        begin
          ld_nxt = 1'b1;
          srcst_nxt = 1'b0;
          first_nxt = 1'b0;
          if (!first_r)
            ptr_nxt = (ptr_r == A_VOL_HI) ? 9'h000
                                          : ptr_r + 9'h001;
        end
        S_SR:
        begin
          ld_nxt = 1'b1;
          srcst_nxt = 1'b1;
        end
        S_SW:
        begin
          swr_nxt = rx;
          swok_nxt = 1'b1;
        end
        default: ;
      endcase
    // Output shifter: load on the falling edge after a byte
    if (fall)
    begin
      if (ld_r)
      begin
        ld_nxt = 1'b0;
        if (srcst_r)
          osr_nxt = {nv_r, wel_r, wip_r};
        else
          osr_nxt = (ptr_r <= A_VOL_HI) ? mrd : 8'h00;
      end
      else
        osr_nxt = {osr_r[6:0], 1'b0};
    end
    // End of frame
    if (csr)
    begin
      if (st_r == S_SW)
      begin
        aswr_nxt = 1'b1;
        if (swok_r && bcnt_r == 3'h0 && wel_r &&
            (!nv_r[NV_HPE] || pin_s2))
        begin
          bsy_nxt = 32'(PROG_CYCLES);
          kind_nxt = K_STAT;
          wip_nxt = 1'b1;
        end
      end
      if (st_r == S_WR && (rg_r == RG_USR || rg_r == RG_REG))
      begin
        if (mask_r != 16'h0 && bcnt_r == 3'h0 && wel_r &&
            !(rg_r == RG_USR && blk_prot(nv_r[1:0], seg_r)))
        begin
          bsy_nxt = 32'(PROG_CYCLES);
          kind_nxt = K_EE;
          wip_nxt = 1'b1;
          step_nxt = 5'h00;
        end
        else
          mask_nxt = 16'h0;
      end
      if (st_r == S_WR && rg_r == RG_VOL && (wrany_r | commit_ok))
        wel_nxt = 1'b0;
    end
    // Idle select clears the decoder
    if (cs_s2)
    begin
      st_nxt = S_OP;
      bcnt_nxt = 3'h0;
      ld_nxt = 1'b0;
      wrany_nxt = 1'b0;
      swok_nxt = 1'b0;
    end
    // Program and restore engine
    if (busy)
    begin
      bsy_nxt = bsy_r - 32'h1;
      if (step_r <= EE_STEPS)
        step_nxt = step_r + 5'h01;
      if (bsy_r == 32'h1)
      begin
        wip_nxt = 1'b0;
        mask_nxt = 16'h0;
        if (kind_r != K_RST)
          wel_nxt = 1'b0;
        if (kind_r == K_STAT)
          nv_nxt = swr_r[7:2];
      end
    end
  end

  // Register the core state
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      st_r <= S_OP;  rg_r <= RG_NONE;  kind_r <= K_STAT;
      bcnt_r <= 3'h0;  sh_r <= 7'h00;  ptr_r <= 9'h000;
      padr_r <= 9'h000;  pdat_r <= 8'h00;  swr_r <= 8'h00;
      osr_r <= 8'h00;  nv_r <= NV_RST;  seg_r <= 5'h00;
      step_r <= 5'h00;  mask_r <= 16'h0;  bsy_r <= 32'h0;
      ophi_r <= 1'b0;  tog_r <= 1'b0;  first_r <= 1'b0;
      wrany_r <= 1'b0;  pend_r <= 1'b0;  swok_r <= 1'b0;
      aswr_r <= 1'b0;  wel_r <= 1'b0;  wip_r <= 1'b0;
      ld_r <= 1'b0;  srcst_r <= 1'b0;  oe_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;  rg_r <= rg_nxt;  kind_r <= kind_nxt;
      bcnt_r <= bcnt_nxt;  sh_r <= sh_nxt;  ptr_r <= ptr_nxt;
      padr_r <= padr_nxt;  pdat_r <= pdat_nxt;  swr_r <= swr_nxt;
      osr_r <= osr_nxt;  nv_r <= nv_nxt;  seg_r <= seg_nxt;
      step_r <= step_nxt;  mask_r <= mask_nxt;  bsy_r <= bsy_nxt;
      ophi_r <= ophi_nxt;  tog_r <= tog_nxt;  first_r <= first_nxt;
      wrany_r <= wrany_nxt;  pend_r <= pend_nxt;  swok_r <= swok_nxt;
      aswr_r <= aswr_nxt;  wel_r <= wel_nxt;  wip_r <= wip_nxt;
      ld_r <= ld_nxt;  srcst_r <= srcst_nxt;  oe_r <= oe_nxt;
    end
  end

  assign MISO    = osr_r[7];
  assign MISO_OE = oe_r;
  assign STATUS  = {nv_r, wel_r, wip_r};

  // ****************************************************************
  // Memory ports
  // ****************************************************************
  // Main port steering: copy engine during restore or user/register segment program, else volatile commits
  always_comb
  begin
    mw_en = 1'b0;
    mw_addr = padr_r;
    mw_data = pdat_r;
    mr_addr = ptr_r;
    bw_en = byte_done & (st_r == S_WR)
          & (rg_r == RG_USR || rg_r == RG_REG);
    if (busy && kind_r == K_RST)
    begin
      mr_addr = A_PIO_DEF + 9'(step_r);
      mw_en = (step_r != 5'h00) && (step_r <= RST_STEPS);
      mw_addr = A_VOL_LO + 9'(sm1);
      mw_data = mrd;
    end
    else if (busy && kind_r == K_EE)
    begin
      mw_en = (step_r != 5'h00) && (step_r <= EE_STEPS)
            && mask_r[sm1[3:0]];
      mw_addr = {seg_r, sm1[3:0]};
      mw_data = brd;
    end
    else
      mw_en = commit_ok;
  end

  smc_mem #(.AW(9)) u_main (
    .clk   (CLK),
    .rst   (RST),
    .we    (mw_en),
    .waddr (mw_addr),
    .wdata (mw_data),
    .raddr (mr_addr),
    .rdata (mrd)
  );

  smc_mem #(.AW(4)) u_buf (
    .clk   (CLK),
    .rst   (RST),
    .we    (bw_en),
    .waddr (ptr_r[3:0]),
    .wdata (rx),
    .raddr (step_r[3:0]),
    .rdata (brd)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_wel_only_set: assert property ($rose(wel_r) |->
    $past(st_r == S_OP && byte_done && rx == OP_SET_WEL))
    else $error("latch set without set command");
  a_swr_refused: assert property (csr && st_r == S_SW &&
    !wel_r |=> !wip_r && !wel_r)
    else $error("refused status write acted");
  a_prog_holds: assert property ($rose(wip_r) |->
    wip_r [*8] ##1 wel_r)
    else $error("program cycle too short");
  a_busy_ignore: assert property (busy && st_r == S_OP &&
    byte_done && rx != OP_ST_RD |=> st_r == S_IGN)
    else $error("command run while busy");
  a_lock_blocks: assert property (!busy && mw_en |->
    wel_r && !nv_r[NV_LOCK] && region_of(mw_addr) == RG_VOL)
    else $error("volatile write not allowed");
  a_vol_wrap: assert property (st_r == S_WR && byte_done &&
    rg_r == RG_VOL && !tog_r && ptr_r == A_VOL_HI
    |=> ptr_r == A_VOL_LO)
    else $error("volatile pointer wrap wrong");
  a_pio_toggle: assert property (st_r == S_WR && byte_done &&
    rg_r == RG_VOL && tog_r && ptr_r == A_VOL_LO
    |=> ptr_r == A_PIO_B)
    else $error("PIO pointer did not alternate");
  a_rd_wrap: assert property (st_r == S_RD && byte_done &&
    !first_r && ptr_r == A_VOL_HI |=> ptr_r == 9'h000)
    else $error("read pointer wrap wrong");
  a_idle_clear: assert property (cs_s2 |=>
    st_r == S_OP && bcnt_r == 3'h0)
    else $error("decoder not cleared when idle");
endmodule

/* smc_pkg.sv */
// Purpose: Shared constants and types of the serial command unit
// Assumes: 200 MHz core clock, 9-bit memory address map
// Notes:   Times are kept in their own unit and converted to cycles here
package smc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS    = 5;
  localparam int PROG_TIME_US     = 10000;
  localparam int PIO_INIT_TIME_US = 1000;
  localparam int PROG_CYC = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int PIO_CYC  = PIO_INIT_TIME_US * 1000 / CLK_PERIOD_NS;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [7:0] OP_SET_WEL = 8'h06;
  localparam logic [7:0] OP_CLR_WEL = 8'h04;
  localparam logic [7:0] OP_ST_WR   = 8'h01;
  localparam logic [7:0] OP_ST_RD   = 8'h05;
  localparam logic [7:0] OP_RESTORE = 8'h07;
  localparam logic [2:0] OP_MEM_WR  = 3'h2;
  localparam logic [2:0] OP_MEM_RD  = 3'h3;

  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam logic [8:0] A_REG_LO  = 9'h100;
  localparam logic [8:0] A_RO_LO   = 9'h110;
  localparam logic [8:0] A_VOL_LO  = 9'h120;
  localparam logic [8:0] A_VOL_HI  = 9'h135;
  localparam logic [8:0] A_PIO_B   = 9'h121;
  localparam logic [8:0] A_PIN_A   = 9'h126;
  localparam logic [8:0] A_PIN_B   = 9'h127;
  localparam logic [8:0] A_PIO_DEF = 9'h10a;
  localparam logic [4:0] RST_STEPS = 5'h06;
  localparam logic [4:0] EE_STEPS  = 5'h10;
  localparam logic [3:0] REG_SKIP  = 4'ha;

  // ****************************************************************
  // Status fields (nonvolatile part holds bits 7:2)
  // ****************************************************************
  localparam int NV_BP   = 0;
  localparam int NV_LOCK = 4;
  localparam int NV_HPE  = 5;
  localparam logic [5:0] NV_RST = 6'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [6:0] {
    S_OP  = 7'h01, S_ADR = 7'h02, S_WR = 7'h04, S_RD = 7'h08,
    S_SR  = 7'h10, S_SW  = 7'h20, S_IGN = 7'h40
  } smc_state_type;
  typedef enum logic [2:0] {
    RG_USR, RG_REG, RG_RO, RG_VOL, RG_NONE
  } smc_region_type;
  typedef enum logic [1:0] {K_STAT, K_EE, K_RST} smc_kind_type;

endpackage

/* smc_mem.sv */
// Purpose: Simple dual-port byte memory with registered read data
// Assumes: One write and one read port on the core clock
// Notes:   Array is not reset; read data register is
`timescale 1ns/10ps
module smc_mem #(
  parameter int AW = 9
)(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output logic [7:0]         rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  // Write array
  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  // Registered read
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= 8'h00;
    else
      rdata <= mem[raddr];
  end
endmodule

/* smc_host.sv */
// Purpose: Host link master model driving frames into the command unit
// Assumes: Modes (0,0) and (1,1), SCK half period of 16 core clocks
// Notes:   SCK idles at the mode's clock idle level between frames; MOSI inverts when released
`timescale 1ns/10ps
module smc_host (
  // Core clock used for pacing
  input  wire logic clk,
  // Link pins
  output logic      sck,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  // Clock idle level: 0 for mode (0,0), 1 for mode (1,1)
  logic cpol;

  initial
  begin
    cpol = 1'b0;
    sck  = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // Wait a number of core clock edges
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Change the link mode while deselected; SCK moves to its idle level
  task automatic set_mode(input logic m);
    @(posedge clk);
    cpol <= m;
    sck  <= m;
    pause(16);
  endtask

  // Open a frame, select held until stop
  task automatic start();
    @(posedge clk);
    cs_n <= 1'b0;
    pause(16);
  endtask

  // Shift n bits MSB first, sample MISO on the rising SCK edge
  task automatic xfer(input logic [7:0] d, input int n,
                      output logic [7:0] q);
    int i;
    q = 8'h00;
    for (i = 7; i > 7 - n; i--)
    begin
      if (cpol)
        sck <= 1'b0;
      mosi <= d[i];
      pause(16);
      sck  <= 1'b1;
      q[i] = miso;
      pause(16);
      if (!cpol)
        sck <= 1'b0;
    end
  endtask

  // Close a frame; the released data line shows the inverse level
  task automatic stop();
    pause(16);
    cs_n <= 1'b1;
    mosi <= ~mosi;
    pause(16);
  endtask
endmodule

/* testbench.sv */
// Purpose: Self-checking bench of the serial command unit
// Assumes: Short program time, memory written before it is read
// Notes:   Frames are byte lists; the last byte may be cut short
`timescale 1ns/10ps
module testbench
  import smc_pkg::*;
;
  localparam int PROG = 2000;
  logic       clk;
  logic       rst;
  logic       sck;
  logic       cs_n;
  logic       mosi;
  logic       miso;
  logic       miso_oe;
  logic       pin_n;
  logic       hcm;
  logic [7:0] status;
  logic [7:0] rx [8];
  int         num_errors;
  int         cmp_count;
  int         oe_cnt;

  // **************************************************************
  // Clock, design and host model
  // **************************************************************
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  smc_core #(.PROG_CYCLES(PROG), .PIO_CYCLES(20)) u_smc_core (
    .CLK(clk), .RST(rst), .SCK(sck), .CS_N(cs_n), .MOSI(mosi),
    .MISO(miso), .MISO_OE(miso_oe), .PROTECT_PIN_N(pin_n),
    .HIGH_CURRENT_MODE(hcm), .STATUS(status));

  smc_host u_smc_host (
    .clk(clk), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  // Count cycles in which the device drives its data line
  always @(posedge clk)
  begin
    if (rst)
      oe_cnt <= 0;
    else if (miso_oe)
      oe_cnt <= oe_cnt + 1;
  end

  // **************************************************************
  // Helper tasks
  // **************************************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // One framed transfer; tail is the bit count of the last byte
  task automatic frame(input logic [7:0] tx [$], input int tail);
    int k;
    u_smc_host.start();
    for (k = 0; k < tx.size(); k++)
      u_smc_host.xfer(tx[k], (k == tx.size() - 1) ? tail : 8, rx[k]);
    u_smc_host.stop();
    repeat (8) @(posedge clk);
  endtask

  // Wait for the program cycle to end, bounded
  task automatic wait_idle();
    int n;
    n = 0;
    while (status[0] !== 1'b0 && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 5000)
      num_errors++;
  endtask

  // Cut a hang short
  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    close_out();
  end

  // **************************************************************
  // Main sequence
  // **************************************************************
  initial
  begin
    int oe0;
    num_errors = 0;
    cmp_count  = 0;
    rst   = 1'b1;
    pin_n = 1'b1;
    hcm   = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    check(status, 8'h00);
    frame('{OP_ST_WR, 8'h0c}, 8);
    check(status, 8'h00);
    frame('{OP_SET_WEL}, 8);
    check(status, 8'h02);
    frame('{OP_CLR_WEL}, 8);
    check(status, 8'h00);
    // Volatile writes: wrap, alternation, dropped tail byte
    frame('{OP_SET_WEL}, 8);
    frame('{8'h0a, 8'h34, 8'h11, 8'h22, 8'h33}, 8);
    check(status, 8'h00);
    @(posedge clk) hcm <= 1'b0;
    frame('{OP_SET_WEL}, 8);
    frame('{8'h0a, 8'h20, 8'ha1, 8'ha2, 8'ha3, 8'h44}, 4);
    check(status, 8'h00);
    // Mode (1,1): the last volatile byte lands at select rise
    u_smc_host.set_mode(1'b1);
    frame('{OP_SET_WEL}, 8);
    frame('{8'h0a, 8'h22, 8'h5a}, 8);
    check(status, 8'h00);
    check(8'(oe_cnt != 0), 8'h00);
    frame('{8'h0b, 8'h22, 8'h00, 8'h00}, 8);
    check(rx[2], 8'h00);
    check(rx[3], 8'h5a);
    u_smc_host.set_mode(1'b0);
    // Read-only, missing and partial writes keep the latch
    frame('{OP_SET_WEL}, 8);
    frame('{8'h0a, 8'h10, 8'h77}, 8);
    check(status, 8'h02);
    frame('{8'h0a, 8'h50, 8'h77}, 8);
    check(status, 8'h02);
    frame('{8'h02, 8'h00, 8'h66}, 4);
    check(status, 8'h02);
    frame('{8'h02, 8'h00, 8'h66}, 8);
    check(status, 8'h03);
    wait_idle();
    check(status, 8'h00);
    // Reads: status byte first, then data with wraps
    frame('{8'h0b, 8'h20, 8'h00, 8'h00, 8'h00}, 8);
    check(rx[2], 8'h00);
    check(rx[3], 8'ha3);
    check(rx[4], 8'ha2);
    frame('{8'h0b, 8'h34, 8'h00, 8'h00, 8'h00, 8'h00}, 8);
    check(rx[3], 8'h11);
    check(rx[4], 8'h22);
    check(rx[5], 8'h66);
    // Status write: last byte used, busy window, status polling
    frame('{OP_SET_WEL}, 8);
    frame('{OP_ST_WR, 8'h3c, 8'h4c}, 8);
    check(status, 8'h03);
    frame('{OP_CLR_WEL}, 8);
    check(status, 8'h03);
    oe0 = oe_cnt;
    frame('{OP_ST_RD, 8'h00, 8'h00}, 8);
    check(8'(oe_cnt != oe0), 8'h01);
    check({7'h00, miso_oe}, 8'h00);
    check(rx[1], 8'h03);
    check(rx[2], 8'h03);
    wait_idle();
    check(status, 8'h4c);
    frame('{OP_ST_RD, 8'h00}, 8);
    check(rx[1], 8'h4c);
    // First read after status write comes from the upper range
    frame('{8'h03, 8'h20, 8'h00, 8'h00}, 8);
    check(rx[2], 8'h4c);
    check(rx[3], 8'ha3);
    // Protected block and locked registers keep the latch
    frame('{OP_SET_WEL}, 8);
    frame('{8'h02, 8'h07, 8'h55}, 8);
    check(status, 8'h4e);
    frame('{8'h0a, 8'h20, 8'h99}, 8);
    check(status, 8'h4e);
    frame('{8'h0b, 8'h20, 8'h00, 8'h00}, 8);
    check(rx[3], 8'ha3);
    frame('{OP_RESTORE}, 8);
    check(status, 8'h4e);
    // Register segment: skipped offsets keep the latch, then defaults
    frame('{8'h0a, 8'h08, 8'hee, 8'hff}, 8);
    check(status, 8'h4e);
    frame('{8'h0a, 8'h0a, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd5}, 8);
    check(status, 8'h4f);
    wait_idle();
    check(status, 8'h4c);
    frame('{OP_RESTORE}, 8);
    frame('{8'h0b, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 8);
    check(rx[3], 8'hd0);
    check(rx[5], 8'hd2);
    check(rx[7], 8'hd4);
    // Protect pin gates status writes once enabled
    frame('{OP_SET_WEL}, 8);
    frame('{OP_ST_WR, 8'hcc}, 8);
    wait_idle();
    check(status, 8'hcc);
    @(posedge clk) pin_n <= 1'b0;
    frame('{OP_SET_WEL}, 8);
    frame('{OP_ST_WR, 8'h80}, 8);
    check(status, 8'hce);
    @(posedge clk) pin_n <= 1'b1;
    frame('{OP_ST_WR, 8'h80}, 8);
    check(status, 8'hcf);
    wait_idle();
    check(status, 8'h80);
    close_out();
  end
endmodule
